// *** design/elrc_pkg.sv ***
// package: constants, register map and types of the event log retrieval
// control; assumes one 100 MHz clock and a synchronous active-high reset
package elrc_pkg;
  // geometry
  localparam int NUM_INPUTS = 16;
  localparam int IDX_W = 4;
  localparam int LOG_DEPTH = 16;
  localparam int SEQ_W = 16;
  localparam int TS_W = 64;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int SEL_W = 16;
  localparam int IRQ_W = 2;
  // register map, byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SELECT = 8'h04;
  localparam logic [7:0] ADDR_ACK = 8'h08;
  localparam logic [7:0] ADDR_EVCLR = 8'h0C;
  localparam logic [7:0] ADDR_UTC_LO = 8'h10;
  localparam logic [7:0] ADDR_UTC_HI = 8'h14;
  localparam logic [7:0] ADDR_CST_LO = 8'h18;
  localparam logic [7:0] ADDR_CST_HI = 8'h1C;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h20;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h24;
  localparam logic [7:0] ADDR_FLAGS = 8'h28;
  localparam logic [7:0] ADDR_COUNT = 8'h2C;
  localparam logic [7:0] ADDR_CUR_NUM = 8'h30;
  localparam logic [7:0] ADDR_CUR_INFO = 8'h34;
  localparam logic [7:0] ADDR_TIME_LO = 8'h38;
  localparam logic [7:0] ADDR_TIME_HI = 8'h3C;
  // field positions
  localparam int CTRL_BY_INPUT_BIT = 0;
  localparam int CTRL_ERASE_BIT = 1;
  localparam int INFO_VALID_BIT = 0;
  localparam int INFO_DIR_BIT = 1;
  localparam int INFO_UTC_BIT = 2;
  localparam int INFO_INPUT_LSB = 8;
  localparam int IRQ_ARRIVAL_BIT = 0;
  localparam int IRQ_OVERFLOW_BIT = 1;
  // drift estimator: fraction bits of the rate and divider steps
  localparam int RATE_FRAC = 24;
  localparam int DIV_STEPS = 56;
  localparam logic [5:0] DIV_LAST = 6'h37;
  typedef enum logic [1:0] {
    ELRC_DIV_IDLE = 2'b00,
    ELRC_DIV_RUN = 2'b01,
    ELRC_DIV_DONE = 2'b11
  } elrc_div_state_t;
endpackage : elrc_pkg

// *** design/elrc_arrival.sv ***
// per-input arrival flags with acknowledge edge detectors
// assumes set and acknowledge vectors come from logic on the same clock
`timescale 1ns/100ps
module elrc_arrival
  import elrc_pkg::*;
#(
  parameter int N = NUM_INPUTS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [N-1:0] set_vec,
  input wire logic [N-1:0] ack_bits,
  output logic [N-1:0] flags
);
  logic [N-1:0] ack_prev_reg;
  logic [N-1:0] flags_reg;
  logic [N-1:0] ack_rise;

  // one independent rising-edge detector per input
  assign ack_rise = ack_bits & ~ack_prev_reg;
  assign flags = flags_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      ack_prev_reg <= '0;
    end else begin
      ack_prev_reg <= ack_bits;
    end
  end

  // a new event beats an acknowledge in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= (flags_reg & ~ack_rise) | set_vec;
    end
  end

  a_flag_set: assert property (@(posedge clk) disable iff (rst)
    (|set_vec) |=> ((flags_reg & $past(set_vec)) == $past(set_vec)))
    else $error("arrival flag not set by event");
  a_flag_clear: assert property (@(posedge clk) disable iff (rst)
    |(ack_bits & ack_prev_reg & flags_reg) |=>
    ((flags_reg & $past(ack_bits & ack_prev_reg & flags_reg)) ==
     $past(ack_bits & ack_prev_reg & flags_reg)))
    else $error("held acknowledge level cleared a flag");
  a_flag_indep: assert property (@(posedge clk) disable iff (rst)
    |ack_rise |=> ((flags_reg & $past(flags_reg & ~ack_rise)) ==
                   $past(flags_reg & ~ack_rise)))
    else $error("acknowledge of one input cleared another");
endmodule : elrc_arrival

// *** design/elrc_utc_conv.sv ***
// system-time to utc converter with drift estimate from reference pairs
// assumes load is a one-cycle pulse carrying a complete new pair
`timescale 1ns/100ps
module elrc_utc_conv
  import elrc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [TS_W-1:0] utc_ref,
  input wire logic [TS_W-1:0] cst_ref,
  input wire logic [TS_W-1:0] cst_in,
  output logic [TS_W-1:0] utc_out,
  output logic utc_mode
);
  elrc_div_state_t state_reg;
  logic [TS_W-1:0] utc_ref_reg;
  logic [TS_W-1:0] cst_ref_reg;
  logic [DATA_W-1:0] rate_reg;
  logic rate_neg_reg;
  logic [DIV_STEPS-1:0] num_reg;
  logic [DATA_W:0] rem_reg;
  logic [DATA_W-1:0] quo_reg;
  logic [DATA_W-1:0] den_reg;
  logic [5:0] cnt_reg;
  logic utc_mode_reg;
  logic pair_nz;
  logic prev_nz;
  logic [TS_W-1:0] d_cst;
  logic [TS_W-1:0] d_utc;
  logic [TS_W-1:0] err;
  logic [DATA_W:0] rem_sh;
  logic signed [TS_W-1:0] delta_s;
  logic signed [DATA_W:0] rate_s;
  logic signed [DATA_W+DATA_W:0] prod;

  assign pair_nz = (utc_ref != '0) && (cst_ref != '0);
  assign prev_nz = (utc_ref_reg != '0) && (cst_ref_reg != '0);
  assign d_cst = cst_ref - cst_ref_reg;
  assign d_utc = utc_ref - utc_ref_reg;
  assign err = (d_utc > d_cst) ? d_utc - d_cst : d_cst - d_utc;
  assign rem_sh = {rem_reg[DATA_W-1:0], num_reg[DIV_STEPS-1]};
  assign utc_mode = utc_mode_reg;

  // reference pair, mode indicator and drift divider
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= ELRC_DIV_IDLE;
      utc_ref_reg <= '0;
      cst_ref_reg <= '0;
      rate_reg <= '0;
      rate_neg_reg <= 1'b0;
      num_reg <= '0;
      rem_reg <= '0;
      quo_reg <= '0;
      den_reg <= '0;
      cnt_reg <= '0;
      utc_mode_reg <= 1'b0;
    end else if (load) begin
      utc_ref_reg <= utc_ref;
      cst_ref_reg <= cst_ref;
      utc_mode_reg <= pair_nz;
      // successive pairs give the clock drift; restart estimate
      if (pair_nz && prev_nz && d_cst[TS_W-1:DATA_W] == '0 &&
          d_cst[DATA_W-1:0] != '0) begin
        num_reg <= {err[DATA_W-1:0], {RATE_FRAC{1'b0}}};
        den_reg <= d_cst[DATA_W-1:0];
        rate_neg_reg <= d_utc < d_cst;
        rem_reg <= '0;
        quo_reg <= '0;
        cnt_reg <= '0;
        state_reg <= ELRC_DIV_RUN;
      end else begin
        rate_reg <= '0;
        state_reg <= ELRC_DIV_IDLE;
      end
    end else begin
      unique case (state_reg)
        ELRC_DIV_IDLE: ;
        ELRC_DIV_RUN: begin
          num_reg <= {num_reg[DIV_STEPS-2:0], 1'b0};
          if (rem_sh >= {1'b0, den_reg}) begin
            rem_reg <= rem_sh - {1'b0, den_reg};
            quo_reg <= {quo_reg[DATA_W-2:0], 1'b1};
          end else begin
            rem_reg <= rem_sh;
            quo_reg <= {quo_reg[DATA_W-2:0], 1'b0};
          end
          cnt_reg <= cnt_reg + 6'h01;
          if (cnt_reg == DIV_LAST) begin
            state_reg <= ELRC_DIV_DONE;
          end
        end
        ELRC_DIV_DONE: begin
          rate_reg <= quo_reg;
          state_reg <= ELRC_DIV_IDLE;
        end
        default: state_reg <= ELRC_DIV_IDLE;
      endcase
    end
  end

  // utc = reference + elapsed system time + drift correction
  assign delta_s = $signed(cst_in - cst_ref_reg);
  assign rate_s = rate_neg_reg ? -$signed({1'b0, rate_reg}) :
                  $signed({1'b0, rate_reg});
  assign prod = $signed(delta_s[DATA_W-1:0]) * rate_s;
  assign utc_out = utc_ref_reg + delta_s +
                   TS_W'(prod >>> RATE_FRAC);

  a_mode_follows: assert property (@(posedge clk) disable iff (rst)
    load |=> (utc_mode_reg == $past(pair_nz)))
    else $error("utc indicator does not follow reference pair");
  a_rate_done: assert property (@(posedge clk) disable iff (rst)
    (state_reg == ELRC_DIV_RUN && !load) [*1] ##1
    (!load) [*8] |-> ##[0:60] (state_reg != ELRC_DIV_RUN))
    else $error("drift estimate never finished");
endmodule : elrc_utc_conv

// *** design/elrc_top.sv ***
// event log retrieval control: register port, event log, retrieval
// assumes event capture logic on CORE_CLK presents one event per strobe
`timescale 1ns/100ps
module elrc_top
  import elrc_pkg::*;
#(
  parameter int DEPTH = LOG_DEPTH
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic [ADDR_W-1:0] REG_ADDR,
  input wire logic [DATA_W-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [DATA_W-1:0] REG_RDATA,
  input wire logic EVT_STROBE,
  input wire logic [IDX_W-1:0] EVT_INPUT,
  input wire logic EVT_DIR,
  input wire logic [TS_W-1:0] EVT_TIME,
  output logic IRQ,
  output logic [NUM_INPUTS-1:0] ARRIVAL_FLAGS,
  output logic UTC_OUTPUT_INDICATOR,
  output logic CURRENT_VALID,
  output logic [SEQ_W-1:0] CURRENT_EVENT_INDEX,
  output logic [IDX_W-1:0] EVENT_INPUT_INDEX,
  output logic EVENT_DIRECTION,
  output logic [TS_W-1:0] EVENT_TIME
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = PTR_W + 1;

  // software-written state
  logic by_input_reg;
  logic erase_reg;
  logic erase_prev_reg;
  logic [SEL_W-1:0] select_reg;
  logic [NUM_INPUTS-1:0] ack_reg;
  logic [TS_W-1:0] utc_ref_reg;
  logic [TS_W-1:0] cst_ref_reg;
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic irq_reg;
  logic [DATA_W-1:0] rdata_reg;
  // event log storage
  logic [DEPTH-1:0] slot_valid_reg;
  logic [IDX_W-1:0] slot_input_reg [DEPTH];
  logic slot_dir_reg [DEPTH];
  logic [SEQ_W-1:0] slot_seq_reg [DEPTH];
  logic [TS_W-1:0] slot_time_reg [DEPTH];
  logic [PTR_W-1:0] head_reg;
  logic [PTR_W-1:0] tail_reg;
  logic [SEQ_W-1:0] seq_reg;
  // current event presentation
  logic cur_valid_reg;
  logic [PTR_W-1:0] cur_ptr_reg;
  logic [SEQ_W-1:0] cur_seq_reg;
  logic [IDX_W-1:0] cur_input_reg;
  logic cur_dir_reg;
  logic [TS_W-1:0] cur_time_reg;
  // combinational terms
  logic erase_rise;
  logic store;
  logic overflow;
  logic clear_hit;
  logic pair_load;
  logic sel_found;
  logic [PTR_W-1:0] sel_ptr;
  logic [NUM_INPUTS-1:0] arrival_set;
  logic [NUM_INPUTS-1:0] flags;
  logic [TS_W-1:0] utc_time;
  logic utc_mode;
  logic [CNT_W-1:0] queued;

  // write-strobe decode shared by all registers
  function automatic logic wr_at(input logic [ADDR_W-1:0] a);
    return REG_WR && (REG_ADDR == a);
  endfunction : wr_at

  // number of slots still holding an event
  function automatic logic [CNT_W-1:0] count_ones(
      input logic [DEPTH-1:0] v);
    logic [CNT_W-1:0] n;
    n = '0;
    for (int i = 0; i < DEPTH; i++) begin
      n = n + CNT_W'(v[i]);
    end
    return n;
  endfunction : count_ones

  assign erase_rise = erase_reg && !erase_prev_reg;
  assign overflow = EVT_STROBE && slot_valid_reg[tail_reg];
  assign store = EVT_STROBE && !slot_valid_reg[tail_reg];
  assign clear_hit = wr_at(ADDR_EVCLR) && cur_valid_reg &&
                     REG_WDATA[SEQ_W-1:0] == cur_seq_reg;
  assign pair_load = wr_at(ADDR_CST_HI);
  assign queued = count_ones(slot_valid_reg);

  // oldest live slot from head, optionally only of the selected input
  always_comb begin
    logic [PTR_W-1:0] p;
    p = '0;
    sel_found = 1'b0;
    sel_ptr = head_reg;
    for (int i = 0; i < DEPTH; i++) begin
      p = head_reg + PTR_W'(i);
      if (!sel_found && slot_valid_reg[p] &&
          (!by_input_reg ||
           {{(SEL_W-IDX_W){1'b0}}, slot_input_reg[p]} == select_reg))
      begin
        sel_found = 1'b1;
        sel_ptr = p;
      end
    end
  end

  // control bits and selected-input field
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      by_input_reg <= 1'b0;
      erase_reg <= 1'b0;
      erase_prev_reg <= 1'b0;
      select_reg <= '0;
      ack_reg <= '0;
    end else begin
      erase_prev_reg <= erase_reg;
      if (wr_at(ADDR_CTRL)) begin
        by_input_reg <= REG_WDATA[CTRL_BY_INPUT_BIT];
        erase_reg <= REG_WDATA[CTRL_ERASE_BIT];
      end
      if (wr_at(ADDR_SELECT)) begin
        select_reg <= REG_WDATA[SEL_W-1:0];
      end
      if (wr_at(ADDR_ACK)) begin
        ack_reg <= REG_WDATA[NUM_INPUTS-1:0];
      end
    end
  end

  // reference pair words; the high system-time word commits the pair
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      utc_ref_reg <= '0;
      cst_ref_reg <= '0;
    end else begin
      if (wr_at(ADDR_UTC_LO)) utc_ref_reg[DATA_W-1:0] <= REG_WDATA;
      if (wr_at(ADDR_UTC_HI)) utc_ref_reg[TS_W-1:DATA_W] <= REG_WDATA;
      if (wr_at(ADDR_CST_LO)) cst_ref_reg[DATA_W-1:0] <= REG_WDATA;
      if (wr_at(ADDR_CST_HI)) cst_ref_reg[TS_W-1:DATA_W] <= REG_WDATA;
    end
  end

  // event log: store at tail, clear by number, erase on edge
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      slot_valid_reg <= '0;
      head_reg <= '0;
      tail_reg <= '0;
      seq_reg <= '0;
    end else if (erase_rise) begin
      // an event in the erase cycle survives as the first entry
      slot_valid_reg <= '0;
      head_reg <= '0;
      tail_reg <= '0;
      if (EVT_STROBE) begin
        slot_valid_reg[0] <= 1'b1;
        tail_reg <= PTR_W'(1);
        seq_reg <= seq_reg + SEQ_W'(1);
      end
    end else begin
      if (clear_hit) begin
        slot_valid_reg[cur_ptr_reg] <= 1'b0;
      end
      if (store) begin
        slot_valid_reg[tail_reg] <= 1'b1;
        tail_reg <= tail_reg + PTR_W'(1);
        seq_reg <= seq_reg + SEQ_W'(1);
      end
      // a full ring has head equal to tail; the count tells it from empty
      if (!slot_valid_reg[head_reg] &&
          (head_reg != tail_reg || queued != '0)) begin
        head_reg <= head_reg + PTR_W'(1);
      end
    end
  end

  // slot payload, written wherever an event lands
  always_ff @(posedge CORE_CLK) begin
    if (store || (erase_rise && EVT_STROBE)) begin
      slot_input_reg[erase_rise ? '0 : tail_reg] <= EVT_INPUT;
      slot_dir_reg[erase_rise ? '0 : tail_reg] <= EVT_DIR;
      slot_seq_reg[erase_rise ? '0 : tail_reg] <= seq_reg;
      slot_time_reg[erase_rise ? '0 : tail_reg] <= EVT_TIME;
    end
  end

  // one arrival flag per input, set by every strobed event, stored or dropped
  always_comb begin
    arrival_set = '0;
    if (EVT_STROBE) begin
      arrival_set[EVT_INPUT] = 1'b1;
    end
  end

  elrc_arrival #(
    .N(NUM_INPUTS)
  ) u_arrival (
    .clk(CORE_CLK),
    .rst(RST),
    .set_vec(arrival_set),
    .ack_bits(ack_reg),
    .flags(flags)
  );

  elrc_utc_conv u_conv (
    .clk(CORE_CLK),
    .rst(RST),
    .load(pair_load),
    .utc_ref({utc_ref_reg[TS_W-1:DATA_W],
              utc_ref_reg[DATA_W-1:0]}),
    .cst_ref({REG_WDATA, cst_ref_reg[DATA_W-1:0]}),
    .cst_in(slot_time_reg[sel_ptr]),
    .utc_out(utc_time),
    .utc_mode(utc_mode)
  );

  // current event registers, refreshed every cycle
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      cur_valid_reg <= 1'b0;
      cur_ptr_reg <= '0;
      cur_seq_reg <= '0;
      cur_input_reg <= '0;
      cur_dir_reg <= 1'b0;
      cur_time_reg <= '0;
    end else begin
      cur_valid_reg <= sel_found && !erase_rise &&
                       !(clear_hit && sel_ptr == cur_ptr_reg);
      cur_ptr_reg <= sel_ptr;
      cur_seq_reg <= slot_seq_reg[sel_ptr];
      cur_input_reg <= slot_input_reg[sel_ptr];
      cur_dir_reg <= slot_dir_reg[sel_ptr];
      cur_time_reg <= utc_mode ? utc_time :
                      slot_time_reg[sel_ptr];
    end
  end

  // sticky interrupt status, write one to clear, set wins
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      if (wr_at(ADDR_IRQ_MASK)) irq_mask_reg <= REG_WDATA[IRQ_W-1:0];
      irq_stat_reg <= (irq_stat_reg &
                       ~(wr_at(ADDR_IRQ_STAT) ? REG_WDATA[IRQ_W-1:0] :
                         IRQ_W'(0))) |
                      {overflow, store};
      irq_reg <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // read port: data in the cycle after the strobe, unmapped reads zero
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      rdata_reg <= '0;
    end else if (REG_RD) begin
      unique case (REG_ADDR)
        ADDR_CTRL: rdata_reg <= DATA_W'({erase_reg, by_input_reg});
        ADDR_SELECT: rdata_reg <= DATA_W'(select_reg);
        ADDR_ACK: rdata_reg <= DATA_W'(ack_reg);
        ADDR_UTC_LO: rdata_reg <= utc_ref_reg[DATA_W-1:0];
        ADDR_UTC_HI: rdata_reg <= utc_ref_reg[TS_W-1:DATA_W];
        ADDR_CST_LO: rdata_reg <= cst_ref_reg[DATA_W-1:0];
        ADDR_CST_HI: rdata_reg <= cst_ref_reg[TS_W-1:DATA_W];
        ADDR_IRQ_STAT: rdata_reg <= DATA_W'(irq_stat_reg);
        ADDR_IRQ_MASK: rdata_reg <= DATA_W'(irq_mask_reg);
        ADDR_FLAGS: rdata_reg <= DATA_W'(flags);
        ADDR_COUNT: rdata_reg <= DATA_W'(queued);
        ADDR_CUR_NUM: rdata_reg <= DATA_W'(cur_seq_reg);
        ADDR_CUR_INFO: rdata_reg <= DATA_W'({cur_input_reg, 5'h00,
          utc_mode, cur_dir_reg, cur_valid_reg});
        ADDR_TIME_LO: rdata_reg <= cur_time_reg[DATA_W-1:0];
        ADDR_TIME_HI: rdata_reg <= cur_time_reg[TS_W-1:DATA_W];
        default: rdata_reg <= '0;
      endcase
    end else begin
      rdata_reg <= '0;
    end
  end

  assign REG_RDATA = rdata_reg;
  assign IRQ = irq_reg;
  assign ARRIVAL_FLAGS = flags;
  assign UTC_OUTPUT_INDICATOR = utc_mode;
  assign CURRENT_VALID = cur_valid_reg;
  assign CURRENT_EVENT_INDEX = cur_seq_reg;
  assign EVENT_INPUT_INDEX = cur_input_reg;
  assign EVENT_DIRECTION = cur_dir_reg;
  assign EVENT_TIME = cur_time_reg;

  sequence s_clear_write;
    clear_hit ##1 1'b1;
  endsequence

  a_erase_empty: assert property (@(posedge CORE_CLK) disable iff (RST)
    erase_rise && !EVT_STROBE |=> (queued == '0) && !cur_valid_reg)
    else $error("log not empty after erase");
  a_select_by_input: assert property (@(posedge CORE_CLK) disable iff (RST)
    by_input_reg && sel_found |=>
      {{(SEL_W-IDX_W){1'b0}}, cur_input_reg} == $past(select_reg))
    else $error("per-input retrieval returned another input");
  a_select_write: assert property (@(posedge CORE_CLK) disable iff (RST)
    REG_WR && REG_ADDR == ADDR_SELECT |=>
      select_reg == $past(REG_WDATA[SEL_W-1:0]))
    else $error("selected-input field not written");
  a_clear_event: assert property (@(posedge CORE_CLK) disable iff (RST)
    s_clear_write |-> !slot_valid_reg[$past(cur_ptr_reg)])
    else $error("event clear did not remove the current event");
  a_order_head: assert property (@(posedge CORE_CLK) disable iff (RST)
    !by_input_reg && slot_valid_reg[head_reg] |-> sel_ptr == head_reg)
    else $error("sequential retrieval skipped the oldest event");
  a_store_fields: assert property (@(posedge CORE_CLK) disable iff (RST)
    store && !erase_rise |=>
      slot_input_reg[$past(tail_reg)] == $past(EVT_INPUT))
    else $error("stored event lost its input index");
  a_raw_time: assert property (@(posedge CORE_CLK) disable iff (RST)
    !utc_mode |=> cur_time_reg == $past(slot_time_reg[sel_ptr]))
    else $error("system time altered while utc is off");
endmodule : elrc_top

// *** testbench/elrc_evt_src.sv ***
// event source model standing in for the capture logic
// assumes one clock shared with the block; one send call per event
`timescale 1ns/100ps
module elrc_evt_src (
  input wire logic clk,
  output logic strobe,
  output logic [3:0] idx,
  output logic dir,
  output logic [63:0] stamp
);
  // quiet outputs at time zero
  initial begin
    strobe = 1'h0;
    idx = 4'h0;
    dir = 1'h0;
    stamp = 64'h0;
  end
  // one-cycle pulse; fields scrambled outside it so nothing stale reads
  task automatic send(input logic [3:0] i, input logic d,
                      input logic [63:0] t);
    @(posedge clk);
    strobe <= 1'h1;
    idx <= i;
    dir <= d;
    stamp <= t;
    @(posedge clk);
    strobe <= 1'h0;
    idx <= ~i;
    dir <= ~d;
    stamp <= ~t;
  endtask : send
endmodule : elrc_evt_src

// *** testbench/elrc_top_tb_top.sv ***
// testbench: register tasks and event scenarios for the retrieval control
// assumes the event source model drives the capture side of the block
`timescale 1ns/100ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin \
  miscompares++; $display("unexpected %0t: %h not %h", $time, a, e); end end
module elrc_top_tb_top;
  import elrc_pkg::*;
  logic clk, rst, wr, rd, strobe, dir, irq, ind, cv, edir;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] idx, ein;
  logic [63:0] stamp, etime;
  logic [15:0] flags, cur;
  int miscompares = 0;
  int comparisons = 0;
  elrc_evt_src src (.clk(clk), .strobe(strobe), .idx(idx), .dir(dir),
    .stamp(stamp));
  elrc_top dut (.CORE_CLK(clk), .RST(rst), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
    .EVT_STROBE(strobe), .EVT_INPUT(idx), .EVT_DIR(dir), .EVT_TIME(stamp),
    .IRQ(irq), .ARRIVAL_FLAGS(flags), .UTC_OUTPUT_INDICATOR(ind),
    .CURRENT_VALID(cv), .CURRENT_EVENT_INDEX(cur), .EVENT_INPUT_INDEX(ein),
    .EVENT_DIRECTION(edir), .EVENT_TIME(etime));
  // 100 MHz clock
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // one-cycle write strobe
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask : wr_reg
  // read data taken in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1 v = rdata;
  endtask : rd_reg
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : idle
  // reference pair, committed by the last word
  task automatic set_pair(input logic [63:0] u, input logic [63:0] c);
    wr_reg(ADDR_UTC_LO, u[31:0]);
    wr_reg(ADDR_UTC_HI, u[63:32]);
    wr_reg(ADDR_CST_LO, c[31:0]);
    wr_reg(ADDR_CST_HI, c[63:32]);
  endtask : set_pair
  task automatic final_report;
    $display("checks %0d mismatches %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report
  // watchdog well past the expected run length
  initial begin
    #100000;
    miscompares++;
    final_report;
  end
  // scenarios
  initial begin
    rst = 1'h1;
    wr = 1'h0;
    rd = 1'h0;
    addr = 8'h0;
    wdata = 32'h0;
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    idle(2);
    rd_reg(ADDR_FLAGS, d);
    `CHK(d, 32'h0)
    `CHK(ind, 1'h0)
    rd_reg(8'hFC, d);
    `CHK(d, 32'h0)
    wr_reg(ADDR_IRQ_MASK, 32'h1);
    src.send(4'h3, 1'h1, 64'h100);
    idle(3);
    `CHK(flags, 16'h0008)
    `CHK({cv, cur, ein, edir}, {1'h1, 16'h0, 4'h3, 1'h1})
    `CHK(etime, 64'h100)
    `CHK(irq, 1'h1)
    wr_reg(ADDR_IRQ_STAT, 32'h1);
    idle(2);
    `CHK(irq, 1'h0)
    src.send(4'h5, 1'h0, 64'h200);
    idle(2);
    wr_reg(ADDR_ACK, 32'h8);
    idle(2);
    `CHK(flags, 16'h0020)
    src.send(4'h3, 1'h0, 64'h300);
    idle(2);
    wr_reg(ADDR_ACK, 32'h8);
    idle(2);
    `CHK(flags, 16'h0028)
    wr_reg(ADDR_ACK, 32'h0);
    wr_reg(ADDR_ACK, 32'h8);
    idle(2);
    `CHK(flags, 16'h0020)
    wr_reg(ADDR_EVCLR, 32'h0);
    idle(2);
    `CHK({cv, cur, ein}, {1'h1, 16'h1, 4'h5})
    wr_reg(ADDR_SELECT, 32'h3);
    wr_reg(ADDR_CTRL, 32'h1);
    idle(2);
    `CHK({cur, ein, etime}, {16'h2, 4'h3, 64'h300})
    wr_reg(ADDR_CTRL, 32'h0);
    idle(2);
    `CHK({cur, ein}, {16'h1, 4'h5})
    wr_reg(ADDR_CTRL, 32'h2);
    idle(2);
    `CHK(cv, 1'h0)
    rd_reg(ADDR_COUNT, d);
    `CHK(d, 32'h0)
    set_pair(64'h5000, 64'h100);
    idle(70);
    `CHK(ind, 1'h1)
    src.send(4'h7, 1'h1, 64'h100);
    idle(3);
    `CHK({ein, etime}, {4'h7, 64'h5000})
    set_pair(64'h6010, 64'h1100);
    idle(70);
    `CHK(etime, 64'h5000)
    set_pair(64'h0, 64'h0);
    idle(3);
    `CHK(ind, 1'h0)
    final_report;
  end
endmodule : elrc_top_tb_top
